// file: hw/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // Two stages; only the second is visible
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o  <= meta;
  end

endmodule

// file: hw/led_matrix_regs.sv
`timescale 1ns/1ps
module led_matrix_regs (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       link_clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [1:0] addr_sel_i,
  input  wire logic [7:0] frame_status_i,
  input  wire logic [2:0] scan_page_i,
  input  wire logic [3:0] scan_row_i,
  input  wire logic [3:0] scan_col_i,
  output logic            led_on_o,
  output logic            led_blink_o,
  output logic [7:0]      led_duty_o,
  output logic [7:0]      page_sel_o,
  output logic            shutdown_o
);

  // Link domain state
  logic                      lrst;
  logic                      lce;
  logic                      scl_s;
  logic                      sda_s;
  logic [1:0]                ad_s;
  logic                      scl_q;
  logic                      sda_q;
  led_matrix_pkg::link_state_e state;
  logic [3:0]                cnt;
  logic                      in_ack;
  logic                      rd_mode;
  logic                      nack;
  logic [7:0]                shreg;
  logic [7:0]                ptr;
  logic [7:0]                tx;
  logic                      rd_wait;
  logic                      ack_p;

  // Request words held stable across the handshake
  logic                      req_tgl;
  logic                      req_wr;
  logic [7:0]                req_addr;
  logic [7:0]                req_wdata;

  // Core domain state
  logic                      req_p;
  logic                      acc;
  logic                      ack_tgl;
  logic [7:0]                rdata;
  logic [7:0]                next_rdata;
  logic [7:0]                func [led_matrix_pkg::FUNC_REGS];
  logic [7:0]                frame_mem [led_matrix_pkg::NUM_FRAMES]
                                       [led_matrix_pkg::FRAME_BYTES];
  logic                      frame_page;
  logic                      in_shutdown;
  logic [7:0]                on_idx;
  logic [7:0]                blink_idx;
  logic [7:0]                duty_idx;

  // Pins and control into the link domain
  bit_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .clk_i(link_clk_i),
    .d_i  ({srst_i, ce_i, addr_sel_i, scl_i, sda_i}),
    .q_o  ({lrst, lce, ad_s, scl_s, sda_s})
  );

  toggle_to_pulse u_ack_sync (
    .clk_i  (link_clk_i),
    .rst_i  (lrst),
    .ce_i   (lce),
    .tgl_i  (ack_tgl),
    .pulse_o(ack_p)
  );

  toggle_to_pulse u_req_sync (
    .clk_i  (core_clk_i),
    .rst_i  (srst_i),
    .ce_i   (ce_i),
    .tgl_i  (req_tgl),
    .pulse_o(req_p)
  );

  // Line history for edge, start and stop detection
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (lce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Open-drain: only ever pull low
  always_ff @(posedge link_clk_i) begin
    sda_o <= 1'b0;
  end

  // Byte engine: address, pointer, write data, read data
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      state     <= led_matrix_pkg::L_IDLE;
      cnt       <= 4'h0;
      in_ack    <= 1'b0;
      rd_mode   <= 1'b0;
      nack      <= 1'b0;
      shreg     <= 8'h00;
      ptr       <= 8'h00;
      tx        <= 8'h00;
      rd_wait   <= 1'b0;
      sda_oe_o  <= 1'b0;
      req_tgl   <= 1'b0;
      req_wr    <= 1'b0;
      req_addr  <= 8'h00;
      req_wdata <= 8'h00;
    end else if (lce) begin
      if (scl_s && scl_q && sda_q && !sda_s) begin
        // Start or repeated start; pointer is kept
        state    <= led_matrix_pkg::L_ADDR;
        cnt      <= 4'h0;
        in_ack   <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (scl_s && scl_q && !sda_q && sda_s) begin
        state    <= led_matrix_pkg::L_IDLE;
        sda_oe_o <= 1'b0;
      end else if (state == led_matrix_pkg::L_IDLE) begin
        sda_oe_o <= 1'b0;
      end else if (scl_s && !scl_q) begin
        // Sample on the rising edge
        if (in_ack) begin
          nack <= sda_s;
        end else begin
          shreg <= {shreg[6:0], sda_s};
          cnt   <= cnt + 4'h1;
        end
      end else if (!scl_s && scl_q) begin
        if (!in_ack && cnt == led_matrix_pkg::BITS_PER_BYTE) begin
          in_ack <= 1'b1;
          case (state)
            led_matrix_pkg::L_ADDR: begin
              if (shreg[7:1] == {led_matrix_pkg::SLAVE_ADDR_HI, ad_s}) begin
                sda_oe_o <= 1'b1;
                rd_mode  <= shreg[0];
              end else begin
                state <= led_matrix_pkg::L_IDLE; // Not ours: stay off the bus
              end
            end
            led_matrix_pkg::L_REG: begin
              sda_oe_o <= 1'b1;
              ptr      <= shreg;
            end
            led_matrix_pkg::L_WDATA: begin
              sda_oe_o  <= 1'b1;
              req_wr    <= 1'b1;
              req_addr  <= ptr;
              req_wdata <= shreg;
              req_tgl   <= ~req_tgl;
              ptr       <= ptr + 8'h01;
            end
            default: begin
              sda_oe_o <= 1'b0; // Master answers the read byte
            end
          endcase
        end else if (in_ack) begin
          in_ack   <= 1'b0;
          cnt      <= 4'h0;
          sda_oe_o <= 1'b0;
          case (state)
            led_matrix_pkg::L_ADDR: begin
              if (rd_mode) begin
                state    <= led_matrix_pkg::L_RDATA;
                rd_wait  <= 1'b1;
                req_wr   <= 1'b0;
                req_addr <= ptr;
                req_tgl  <= ~req_tgl;
                ptr      <= ptr + 8'h01;
              end else begin
                state <= led_matrix_pkg::L_REG;
              end
            end
            led_matrix_pkg::L_REG: begin
              state <= led_matrix_pkg::L_WDATA;
            end
            led_matrix_pkg::L_RDATA: begin
              if (nack) begin
                state <= led_matrix_pkg::L_IDLE;
              end else begin
                rd_wait  <= 1'b1;
                req_wr   <= 1'b0;
                req_addr <= ptr;
                req_tgl  <= ~req_tgl;
                ptr      <= ptr + 8'h01;
              end
            end
            default: begin
              state <= state;
            end
          endcase
        end else if (state == led_matrix_pkg::L_RDATA && !rd_wait) begin
          sda_oe_o <= ~tx[3'(4'h7 - cnt)];
        end
      end else if (ack_p && rd_wait) begin
        // Read word arrives within the low phase of the clock
        tx       <= rdata;
        rd_wait  <= 1'b0;
        sda_oe_o <= ~rdata[7];
      end
    end
  end

  // Core side access strobe
  assign acc         = req_p && ce_i && !srst_i;
  assign frame_page  = page_sel_o < led_matrix_pkg::FRAME_PAGES;
  assign in_shutdown = ~func[led_matrix_pkg::F_SHUTDOWN[3:0]][0];

  // Page select holds until rewritten
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      page_sel_o <= led_matrix_pkg::PAGE_RESET;
    end else if (ce_i) begin
      if (acc && req_wr && req_addr == led_matrix_pkg::PAGE_SEL_ADDR) begin
        page_sel_o <= req_wdata;
      end
    end
  end

  // Frame storage has no reset; software must load it
  always_ff @(posedge core_clk_i) begin
    if (ce_i && acc && req_wr && frame_page &&
        req_addr <= led_matrix_pkg::FRAME_LAST) begin
      frame_mem[page_sel_o[2:0]][req_addr] <= req_wdata;
    end
  end

  // Function registers; slot 0x04 and status are not stored
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < led_matrix_pkg::FUNC_REGS; i++) begin
        func[i] <= led_matrix_pkg::FUNC_RESET;
      end
    end else if (ce_i) begin
      if (acc && req_wr && page_sel_o == led_matrix_pkg::FUNC_PAGE &&
          req_addr <= led_matrix_pkg::FUNC_LAST &&
          req_addr != led_matrix_pkg::F_UNUSED &&
          req_addr != led_matrix_pkg::F_STATUS) begin
        func[req_addr[3:0]] <= req_wdata;
      end
    end
  end

  // Read mux; reserved pages and locked frames read zero, except page select at 0xFD
  always_comb begin
    next_rdata = 8'h00;
    if (req_addr == led_matrix_pkg::PAGE_SEL_ADDR) begin
      next_rdata = page_sel_o;
    end else if (frame_page) begin
      if (in_shutdown && req_addr <= led_matrix_pkg::FRAME_LAST) begin
        next_rdata = frame_mem[page_sel_o[2:0]][req_addr];
      end
    end else if (page_sel_o == led_matrix_pkg::FUNC_PAGE &&
                 req_addr <= led_matrix_pkg::FUNC_LAST) begin
      if (req_addr == led_matrix_pkg::F_STATUS) begin
        next_rdata = frame_status_i;
      end else if (req_addr != led_matrix_pkg::F_UNUSED) begin
        next_rdata = func[req_addr[3:0]];
      end
    end
  end

  // Answer every request so the link never hangs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata   <= 8'h00;
      ack_tgl <= 1'b0;
    end else if (ce_i && acc) begin
      ack_tgl <= ~ack_tgl;
      if (!req_wr) begin
        rdata <= next_rdata;
      end
    end
  end

  // Shutdown flag: bit 0 low means shut down
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      shutdown_o <= 1'b1;
    end else if (ce_i) begin
      shutdown_o <= in_shutdown;
    end
  end

  // Scan port: row 0..8, column 0..15, columns 8+ are matrix B
  assign on_idx    = led_matrix_pkg::ONOFF_BASE + {3'h0, scan_row_i, scan_col_i[3]};
  assign blink_idx = led_matrix_pkg::BLINK_BASE + on_idx;
  assign duty_idx  = led_matrix_pkg::DUTY_BASE + {scan_row_i, scan_col_i};

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      led_on_o    <= 1'b0;
      led_blink_o <= 1'b0;
      led_duty_o  <= 8'h00;
    end else if (ce_i) begin
      led_on_o    <= frame_mem[scan_page_i][on_idx][scan_col_i[2:0]];
      led_blink_o <= frame_mem[scan_page_i][blink_idx][scan_col_i[2:0]];
      led_duty_o  <= frame_mem[scan_page_i][duty_idx];
    end
  end

  // Checks, all in the core domain
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i || !ce_i);

  sequence s_rd;
    acc && !req_wr;
  endsequence

  sequence s_wr;
    acc && req_wr;
  endsequence

  sequence s_func_rd;
    s_rd ##0 (page_sel_o == led_matrix_pkg::FUNC_PAGE);
  endsequence

  property p_page_sel;
    s_wr ##0 (req_addr == led_matrix_pkg::PAGE_SEL_ADDR)
      |=> page_sel_o == $past(req_wdata);
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("page select not taken");

  // Any stored function slot, not only offset zero, so the bench reaches it
  property p_func_wr;
    s_wr ##0 (page_sel_o == led_matrix_pkg::FUNC_PAGE &&
              req_addr <= led_matrix_pkg::FUNC_LAST &&
              req_addr != led_matrix_pkg::F_UNUSED &&
              req_addr != led_matrix_pkg::F_STATUS)
      |=> func[$past(req_addr[3:0])] == $past(req_wdata);
  endproperty
  a_func_wr: assert property (p_func_wr) else $error("function write lost");

  property p_frame_wr;
    s_wr ##0 (frame_page && req_addr <= led_matrix_pkg::FRAME_LAST)
      |=> frame_mem[$past(page_sel_o[2:0])][$past(req_addr)] == $past(req_wdata);
  endproperty
  a_frame_wr: assert property (p_frame_wr) else $error("frame write lost");

  property p_reserved;
    s_rd ##0 (!frame_page && page_sel_o != led_matrix_pkg::FUNC_PAGE &&
              req_addr != led_matrix_pkg::PAGE_SEL_ADDR) |=> rdata == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved page read");

  property p_rd_lock;
    s_rd ##0 (frame_page && !in_shutdown) |=> rdata == 8'h00;
  endproperty
  a_rd_lock: assert property (p_rd_lock) else $error("frame read while on");

  property p_slot4;
    s_func_rd ##0 (req_addr == led_matrix_pkg::F_UNUSED) |=> rdata == 8'h00;
  endproperty
  a_slot4: assert property (p_slot4) else $error("slot 0x04 read nonzero");

  property p_status;
    s_func_rd ##0 (req_addr == led_matrix_pkg::F_STATUS)
      |=> rdata == $past(frame_status_i);
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_shutdown;
    s_wr ##0 (page_sel_o == led_matrix_pkg::FUNC_PAGE &&
              req_addr == led_matrix_pkg::F_SHUTDOWN)
      |-> ##2 shutdown_o == !$past(req_wdata[0], 2);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown flag wrong");

  // Index worked out from the row stride; unwritten storage may read back unknown
  property p_scan_duty;
    scan_row_i < 4'h9 |=> led_duty_o === $past(frame_mem[scan_page_i]
      [led_matrix_pkg::DUTY_BASE + 8'(scan_row_i) * 8'h10 + 8'(scan_col_i)]);
  endproperty
  a_scan_duty: assert property (p_scan_duty) else $error("duty scan wrong");

endmodule

// file: hw/toggle_to_pulse.sv
`timescale 1ns/1ps
module toggle_to_pulse (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic tgl_i,
  output logic      pulse_o
);

  logic tgl_s;
  logic last;

  bit_sync #(
    .WIDTH(1)
  ) u_sync (
    .clk_i(clk_i),
    .d_i  (tgl_i),
    .q_o  (tgl_s)
  );

  // Pulse holds while frozen, so no event is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last <= 1'b0;
    end else if (ce_i) begin
      last <= tgl_s;
    end
  end

  assign pulse_o = tgl_s ^ last;

endmodule

// file: inc/led_matrix_pkg.sv
package led_matrix_pkg;

  // Paging
  localparam logic [7:0] PAGE_SEL_ADDR = 8'hFD;
  localparam logic [7:0] FUNC_PAGE     = 8'h0B;
  localparam logic [7:0] FRAME_PAGES   = 8'h08;
  localparam logic [7:0] PAGE_RESET    = 8'h00;
  localparam int         NUM_FRAMES    = 8;
  localparam int         FRAME_BYTES   = 180;

  // Frame page layout
  localparam logic [7:0] ONOFF_BASE    = 8'h00;
  localparam logic [7:0] BLINK_BASE    = 8'h12;
  localparam logic [7:0] DUTY_BASE     = 8'h24;
  localparam logic [7:0] FRAME_LAST    = 8'hB3;

  // Function page layout
  localparam logic [7:0] F_CONFIG      = 8'h00;
  localparam logic [7:0] F_STILL       = 8'h01;
  localparam logic [7:0] F_ANIM_ONE    = 8'h02;
  localparam logic [7:0] F_ANIM_DELAY  = 8'h03;
  localparam logic [7:0] F_UNUSED      = 8'h04;
  localparam logic [7:0] F_DISPLAY     = 8'h05;
  localparam logic [7:0] F_AUDIO_SYNC  = 8'h06;
  localparam logic [7:0] F_STATUS      = 8'h07;
  localparam logic [7:0] F_FADE_TIMES  = 8'h08;
  localparam logic [7:0] F_FADE_CTRL   = 8'h09;
  localparam logic [7:0] F_SHUTDOWN    = 8'h0A;
  localparam logic [7:0] F_GAIN        = 8'h0B;
  localparam logic [7:0] F_SAMPLE_RATE = 8'h0C;
  localparam logic [7:0] FUNC_LAST     = 8'h0C;
  localparam int         FUNC_REGS     = 13;
  localparam logic [7:0] FUNC_RESET    = 8'h00;

  // Serial link
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h1D;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum {
    L_IDLE,
    L_ADDR,
    L_REG,
    L_WDATA,
    L_RDATA
  } link_state_e;

endpackage

// file: tb/i2c_master_model.sv
`timescale 1ns/1ps
// Behavioural bus master; SCL rests high between frames, SDA is open drain
module i2c_master_model (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  // Low phase is ten link clocks, room for the read fetch; short high keeps runs brief
  localparam time T_LOW  = 1250ns;
  localparam time T_HIGH = 250ns;

  // Bus released at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // START, or repeated START when entered from the low phase
  task automatic start();
    sda_o = 1'b1;
    #(T_LOW / 2);
    scl_o = 1'b1;
    #T_HIGH;
    sda_o = 1'b0;
    #T_HIGH;
    scl_o = 1'b0;
  endtask

  // One bit slot; data changes only while SCL is low
  task automatic bit_slot(input logic b, output logic s);
    #(T_LOW / 2);
    sda_o = b;
    #(T_LOW / 2);
    scl_o = 1'b1;
    #(T_HIGH / 2);
    s = sda_i;
    #(T_HIGH / 2);
    scl_o = 1'b0;
  endtask

  // MSB first, ninth slot released so the slave can pull low
  task automatic write_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], s);
    end
    bit_slot(1'b1, ack_n);
  endtask

  // Last byte of a read is refused so the slave lets go
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(last, s);
  endtask

  // STOP, then bus free time
  task automatic stop();
    #(T_LOW / 2);
    sda_o = 1'b0;
    #(T_LOW / 2);
    scl_o = 1'b1;
    #T_HIGH;
    sda_o = 1'b1;
    #T_HIGH;
  endtask
endmodule

// file: tb/led_matrix_regs_tb_top.sv
`timescale 1ns/1ps
module led_matrix_regs_tb_top;
  logic       clk = 1'b0;
  logic       link_clk;
  logic       srst;
  logic       scl;
  logic       mst_sda;
  logic       sda_oe;
  logic       sda_drv;
  logic [1:0] addr_sel;
  logic [7:0] frame_status;
  logic [2:0] scan_page;
  logic [3:0] scan_row;
  logic [3:0] scan_col;
  logic       led_on;
  logic       led_blink;
  logic [7:0] led_duty;
  logic [7:0] page_sel;
  logic       shutdown;
  wire        sda_line;
  int         error_cnt = 0;
  int         compares = 0;

  // Pull-up wins unless either party pulls low
  assign sda_line = mst_sda & ~sda_oe;

  // Core clock, 4 ns period
  always #2 clk = ~clk;

  // Link clock, 125 ns, phase unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  led_matrix_regs DUT (
    .core_clk_i     (clk),
    .srst_i         (srst),
    .ce_i           (1'b1),
    .link_clk_i     (link_clk),
    .scl_i          (scl),
    .sda_i          (sda_line),
    .sda_o          (sda_drv),
    .sda_oe_o       (sda_oe),
    .addr_sel_i     (addr_sel),
    .frame_status_i (frame_status),
    .scan_page_i    (scan_page),
    .scan_row_i     (scan_row),
    .scan_col_i     (scan_col),
    .led_on_o       (led_on),
    .led_blink_o    (led_blink),
    .led_duty_o     (led_duty),
    .page_sel_o     (page_sel),
    .shutdown_o     (shutdown)
  );

  i2c_master_model mst (
    .scl_o (scl),
    .sda_o (mst_sda),
    .sda_i (sda_line)
  );

  // Compare and count; X never matches
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Write frame: pointer then one or two data bytes
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
                    input int n, input bit chk);
    logic a;
    mst.start();
    mst.write_byte({led_matrix_pkg::SLAVE_ADDR_HI, addr_sel, 1'b0}, a);
    check({7'h0, a}, 8'h00, "address ack");
    mst.write_byte(ptr, a);
    check({7'h0, a}, 8'h00, "pointer ack");
    mst.write_byte(d0, a);
    if (chk) check({7'h0, a}, 8'h00, "data ack");
    if (n > 1) begin
      mst.write_byte(d1, a);
      if (chk) check({7'h0, a}, 8'h00, "second data ack");
    end
    mst.stop();
  endtask

  // Page is chosen before any other access
  task automatic sel(input logic [7:0] p);
    wr(led_matrix_pkg::PAGE_SEL_ADDR, p, 8'h00, 1, 1'b1);
  endtask

  // Pointer, repeated START, n bytes (up to four); byte k lands in d[8k+7:8k]
  task automatic rd(input logic [7:0] ptr, input int n, output logic [31:0] d);
    logic       a;
    logic [7:0] b;
    d = 32'h0000_0000;
    mst.start();
    mst.write_byte({led_matrix_pkg::SLAVE_ADDR_HI, addr_sel, 1'b0}, a);
    mst.write_byte(ptr, a);
    mst.start();
    mst.write_byte({led_matrix_pkg::SLAVE_ADDR_HI, addr_sel, 1'b1}, a);
    check({7'h0, a}, 8'h00, "read address ack");
    for (int k = 0; k < n; k++) begin
      mst.read_byte(k == n - 1, b);
      d[8*k +: 8] = b;
    end
    mst.stop();
  endtask

  // Lookup is registered; sample well after it settles
  task automatic scan(input logic [2:0] pg, input logic [3:0] row, input logic [3:0] col);
    @(posedge clk);
    scan_page <= pg;
    scan_row  <= row;
    scan_col  <= col;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic s_reset();
    check({7'h0, shutdown}, 8'h01, "shutdown after reset");
    check(page_sel, led_matrix_pkg::PAGE_RESET, "page after reset");
    check({7'h0, sda_oe}, 8'h00, "data line released");
    check({7'h0, sda_drv}, 8'h00, "open-drain drive level");
  endtask

  // Fourth frame, second row: both matrices, blink and one duty byte
  task automatic s_frame();
    logic [15:0] row_bits;
    row_bits = 16'h3CA5;
    sel(8'h03);
    check(page_sel, 8'h03, "frame page select");
    wr(8'h02, 8'hA5, 8'h3C, 2, 1'b1);
    for (int c = 0; c < 16; c++) begin
      scan(3'h3, 4'h1, c[3:0]);
      check({7'h0, led_on}, {7'h0, row_bits[c]}, "on/off column");
    end
    wr(8'h15, 8'h81, 8'h00, 1, 1'b1);
    for (int c = 8; c < 16; c++) begin
      scan(3'h3, 4'h1, c[3:0]);
      check({7'h0, led_blink}, {7'h0, (c == 8 || c == 15)}, "blink column");
    end
    wr(8'h3F, 8'h5A, 8'h00, 1, 1'b1);
    scan(3'h3, 4'h1, 4'hB);
    check(led_duty, 8'h5A, "duty byte");
  endtask

  // Writes under a reserved page must leave frame storage alone
  task automatic s_reserved();
    logic [31:0] d;
    sel(8'h08);
    wr(8'h02, 8'h00, 8'h00, 2, 1'b0);
    rd(8'h02, 1, d);
    check(d[7:0], 8'h00, "reserved page read");
    scan(3'h3, 4'h1, 4'h0);
    check({7'h0, led_on}, 8'h01, "matrix A kept");
    scan(3'h3, 4'h1, 4'hA);
    check({7'h0, led_on}, 8'h01, "matrix B kept");
  endtask

  // Leave shutdown, read slots 0x04..0x07 while running, then a locked frame
  task automatic s_func();
    logic [31:0] d;
    @(posedge clk);
    frame_status <= 8'h93;
    sel(led_matrix_pkg::FUNC_PAGE);
    check(page_sel, 8'h0B, "function page select");
    wr(led_matrix_pkg::F_SHUTDOWN, 8'h01, 8'h00, 1, 1'b1);
    check({7'h0, shutdown}, 8'h00, "operating mode");
    rd(led_matrix_pkg::F_UNUSED, 4, d);
    check(d[23:16], 8'h00, "audio sync default");
    check(d[31:24], 8'h93, "status read");
    sel(8'h03);
    rd(8'h02, 1, d);
    check(d[7:0], 8'h00, "frame read while running");
  endtask

  // Reset spans several link clocks so the link side sees it too
  initial begin
    srst         = 1'b1;
    addr_sel     = 2'b10;
    frame_status = 8'h00;
    scan_page    = 3'h0;
    scan_row     = 4'h0;
    scan_col     = 4'h0;
    repeat (130) @(posedge clk);
    srst <= 1'b0;
    repeat (130) @(posedge clk);
    s_reset();
    s_frame();
    s_reserved();
    s_func();
    report_and_stop();
  end

  // Cut a hung run short
  initial begin
    repeat (250000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
